/* rtl/root_hub_descriptor_regs.v */
`timescale 1ns/1ns
`include "root_hub_defs.vh"
module root_hub_descriptor_regs
#(
  parameter [7:0] DELAY_RESET    = `RST_DELAY,
  parameter       NOCUR_RESET    = `RST_NOCUR,
  parameter       NOSWITCH_RESET = `RST_NOSWITCH,
  parameter       SWMODE_RESET   = `RST_SWMODE,
  parameter [1:0] PORTS_RESET    = `RST_PORTS,
  parameter [2:0] MASK_RESET     = `RST_MASK,
  parameter [2:0] REMOV_RESET    = `RST_REMOV
)
(
  // clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // command port
  input  wire [7:0]  cmdCode,
  input  wire        cmdValid,
  input  wire [31:0] writeData,
  output reg  [31:0] readData,
  output reg         readValid,
  output wire        writeAccepted,
  // controller state
  input  wire        operationalState,
  // power commands
  input  wire        globalPowerSet,
  input  wire        globalPowerClear,
  input  wire [1:0]  portPowerSet,
  input  wire [1:0]  portPowerClear,
  // status registers written here, owned elsewhere
  output reg         hubStatusWrite,
  output reg  [1:0]  portStatusWrite,
  output reg  [31:0] statusWriteData,
  input  wire [31:0] hubStatusRead,
  input  wire [31:0] port1StatusRead,
  input  wire [31:0] port2StatusRead,
  // decoded configuration
  output wire [7:0]  powerGoodDelay,
  output wire        overcurrentEnabled,
  output wire        overcurrentPerPort,
  output wire [1:0]  portPowerOn
);
  // ----------------------------------------
  // stored fields
  // ----------------------------------------
  reg  [7:0] delay_reg;
  reg        noCur_reg;
  reg        ocMode_reg;
  reg        noSwitch_reg;
  reg        swMode_reg;
  reg  [2:0] mask_reg;
  reg  [2:0] remov_reg;
  wire [1:0] portCount;
  wire       wrFirst;
  wire       wrSecond;
  wire       wrHub;
  wire       wrPort1;
  wire       wrPort2;
  wire       statusWr;
  reg  [31:0] firstWord;
  reg  [31:0] secondWord;

  // port count clamped to the supported maximum
  assign portCount = (PORTS_RESET > `MAX_PORTS) ? `MAX_PORTS
                                                 : PORTS_RESET;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  assign wrFirst  = cmdValid && (cmdCode == `CMD_DESC_FIRST_WR);
  assign wrSecond = cmdValid && (cmdCode == `CMD_DESC_SECOND_WR);
  assign wrHub    = cmdValid && (cmdCode == `CMD_HUB_STATUS_WR);
  assign wrPort1  = cmdValid && (cmdCode == `CMD_PORT1_WR);
  assign wrPort2  = cmdValid && (cmdCode == `CMD_PORT2_WR);
  assign statusWr = (wrHub || wrPort1 || wrPort2) && operationalState;
  assign writeAccepted = wrFirst || wrSecond || statusWr;

  // ----------------------------------------
  // descriptor registers
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      delay_reg    <= DELAY_RESET;
      noCur_reg    <= NOCUR_RESET;
      ocMode_reg   <= SWMODE_RESET;
      noSwitch_reg <= NOSWITCH_RESET;
      swMode_reg   <= SWMODE_RESET;
      mask_reg     <= MASK_RESET;
      remov_reg    <= REMOV_RESET;
    end
    else
    begin
      if (wrFirst)
      begin
        delay_reg    <= writeData[`DELAY_HI:`DELAY_LO];
        noCur_reg    <= writeData[`NOCUR_BIT];
        ocMode_reg   <= writeData[`OCMODE_BIT];
        noSwitch_reg <= writeData[`NOSWITCH_BIT];
        swMode_reg   <= writeData[`SWMODE_BIT];
      end
      if (wrSecond)
      begin
        mask_reg  <= {writeData[`MASK_HI:`MASK_LO+1], 1'b0};
        remov_reg <= {writeData[`REMOV_HI:`REMOV_LO+1], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // read words
  // ----------------------------------------
  always @*
  begin
    firstWord = 32'h00000000;
    firstWord[`DELAY_HI:`DELAY_LO] = delay_reg;
    firstWord[`NOCUR_BIT]    = noCur_reg;
    firstWord[`OCMODE_BIT]   = ocMode_reg;
    firstWord[`COMPOUND_BIT] = 1'b0;
    firstWord[`NOSWITCH_BIT] = noSwitch_reg;
    firstWord[`SWMODE_BIT]   = swMode_reg;
    firstWord[`PORTS_HI:`PORTS_LO] = portCount;
    secondWord = 32'h00000000;
    secondWord[`MASK_HI:`MASK_LO]   = mask_reg;
    secondWord[`REMOV_HI:`REMOV_LO] = remov_reg;
  end

  // ----------------------------------------
  // read port and status write strobes
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      readData        <= 32'h00000000;
      readValid       <= 1'b0;
      hubStatusWrite  <= 1'b0;
      portStatusWrite <= 2'h0;
      statusWriteData <= 32'h00000000;
    end
    else
    begin
      readValid       <= 1'b0;
      hubStatusWrite  <= wrHub && operationalState;
      portStatusWrite <= {wrPort2, wrPort1} & {2{operationalState}};
      if (statusWr)
        statusWriteData <= writeData;
      if (cmdValid)
      begin
        if (cmdCode == `CMD_DESC_FIRST_RD)
        begin
          readData  <= firstWord;
          readValid <= 1'b1;
        end
        else if (cmdCode == `CMD_DESC_SECOND_RD)
        begin
          readData  <= secondWord;
          readValid <= 1'b1;
        end
        else if (cmdCode == `CMD_HUB_STATUS_RD)
        begin
          readData  <= hubStatusRead;
          readValid <= 1'b1;
        end
        else if (cmdCode == `CMD_PORT1_RD)
        begin
          readData  <= port1StatusRead;
          readValid <= 1'b1;
        end
        else if (cmdCode == `CMD_PORT2_RD)
        begin
          readData  <= port2StatusRead;
          readValid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // decoded configuration
  // ----------------------------------------
  assign powerGoodDelay     = delay_reg;
  assign overcurrentEnabled = !noCur_reg;
  assign overcurrentPerPort = !noCur_reg && ocMode_reg;

  // ----------------------------------------
  // per-port power
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : gPort
      port_power_ctl uPower
      (
        .clock       (clock),
        .reset_n     (reset_n),
        .noSwitching (noSwitch_reg),
        .switchMode  (swMode_reg),
        .portMask    (mask_reg[i+1]),
        .globalSet   (globalPowerSet),
        .globalClear (globalPowerClear),
        .portSet     (portPowerSet[i]),
        .portClear   (portPowerClear[i]),
        .powerOn     (portPowerOn[i])
      );
    end
  endgenerate
endmodule // root_hub_descriptor_regs

/* shared/root_hub_defs.vh */
`ifndef ROOT_HUB_DEFS_VH
`define ROOT_HUB_DEFS_VH
// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_DESC_FIRST_RD   8'h12
`define CMD_DESC_FIRST_WR   8'h92
`define CMD_DESC_SECOND_RD  8'h13
`define CMD_DESC_SECOND_WR  8'h93
`define CMD_HUB_STATUS_RD   8'h14
`define CMD_HUB_STATUS_WR   8'h94
`define CMD_PORT1_RD        8'h15
`define CMD_PORT1_WR        8'h95
`define CMD_PORT2_RD        8'h16
`define CMD_PORT2_WR        8'h96
// ----------------------------------------
// first descriptor fields
// ----------------------------------------
`define DELAY_HI            31
`define DELAY_LO            24
`define NOCUR_BIT           12
`define OCMODE_BIT          11
`define COMPOUND_BIT        10
`define NOSWITCH_BIT        9
`define SWMODE_BIT          8
`define PORTS_HI            1
`define PORTS_LO            0
`define MAX_PORTS           2'h2
// ----------------------------------------
// second descriptor fields
// ----------------------------------------
`define MASK_HI             18
`define MASK_LO             16
`define REMOV_HI            2
`define REMOV_LO            0
// ----------------------------------------
// reset values and delay unit
// ----------------------------------------
`define RST_DELAY           8'h19
`define RST_NOCUR           1'h0
`define RST_NOSWITCH        1'h0
`define RST_SWMODE          1'h1
`define RST_PORTS           2'h2
`define RST_MASK            3'h0
`define RST_REMOV           3'h0
`define DELAY_UNIT_MS       2
`endif

/* rtl/port_power_ctl.v */
`timescale 1ns/1ns
`include "root_hub_defs.vh"
module port_power_ctl
(
  // clock and reset
  input  wire clock,
  input  wire reset_n,
  // configuration
  input  wire noSwitching,
  input  wire switchMode,
  input  wire portMask,
  // power commands
  input  wire globalSet,
  input  wire globalClear,
  input  wire portSet,
  input  wire portClear,
  // status
  output reg  powerOn
);
  reg powerOn_next;

  always @*
  begin
    powerOn_next = powerOn;
    if (noSwitching)
      powerOn_next = 1'b1;
    else if (switchMode && portMask)
    begin
      if (portSet) powerOn_next = 1'b1;
      else if (portClear) powerOn_next = 1'b0;
    end
    else
    begin
      if (globalSet) powerOn_next = 1'b1;
      else if (globalClear) powerOn_next = 1'b0;
    end
  end

  always @(posedge clock)
  begin
    if (!reset_n)
      powerOn <= 1'b0;
    else
      powerOn <= powerOn_next;
  end
endmodule // port_power_ctl

/* tb/root_hub_asserts.sv */
`timescale 1ns/1ns
// ----
// root hub port checks
// ----
module root_hub_asserts
(
  // clock and reset
  input wire        clock,
  input wire        reset_n,
  // command port
  input wire [7:0]  cmdCode,
  input wire        cmdValid,
  input wire [31:0] writeData,
  input wire [31:0] readData,
  input wire        readValid,
  input wire        writeAccepted,
  input wire        operationalState,
  // status strobes
  input wire        hubStatusWrite,
  input wire [1:0]  portStatusWrite,
  input wire [31:0] statusWriteData,
  // decoded configuration
  input wire [7:0]  powerGoodDelay,
  input wire        overcurrentEnabled,
  input wire        overcurrentPerPort
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_read_answer: assert property (
    cmdValid && cmdCode == 8'h12 |=> readValid)
    else $error("read answer missing");
  a_read_cause: assert property (
    readValid |-> $past(cmdValid) && !$past(cmdCode[7]))
    else $error("read answer without read");
  a_desc_any: assert property (
    cmdValid && cmdCode == 8'h92 |-> writeAccepted)
    else $error("descriptor write refused");
  a_hub_refuse: assert property (
    cmdValid && cmdCode == 8'h94 && !operationalState
    |-> !writeAccepted ##1 !hubStatusWrite)
    else $error("status write not refused");
  a_hub_accept: assert property (
    cmdValid && cmdCode == 8'h94 && operationalState
    |-> ##1 hubStatusWrite && statusWriteData == $past(writeData))
    else $error("hub strobe");
  a_port_strobe: assert property (
    cmdValid && cmdCode == 8'h96 && operationalState
    |=> portStatusWrite == 2'h2)
    else $error("port two strobe");
  a_fixed_bits: assert property (
    cmdValid && cmdCode == 8'h12
    |=> readData[1:0] != 2'h3 && (readData & 32'h00FFE4FC) == 32'h00000000)
    else $error("fixed bits");
  a_delay_write: assert property (
    cmdValid && cmdCode == 8'h92
    |=> powerGoodDelay == $past(writeData[31:24]))
    else $error("delay not written");
  a_oc_decode: assert property (
    cmdValid && cmdCode == 8'h92 |=>
    overcurrentEnabled != $past(writeData[12]) && overcurrentPerPort ==
    (!$past(writeData[12]) && $past(writeData[11])))
    else $error("overcurrent decode");
  c_desc_write: cover property (cmdValid && cmdCode == 8'h92);
  c_hub_write: cover property (hubStatusWrite);
  c_per_port: cover property (overcurrentPerPort);
endmodule // root_hub_asserts

/* tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic        clock, reset_n, cmdValid, operationalState, readValid;
  logic        writeAccepted, hubStatusWrite, globalPowerSet;
  logic        globalPowerClear, overcurrentEnabled, overcurrentPerPort;
  logic [7:0]  cmdCode, powerGoodDelay;
  logic [1:0]  portPowerSet, portPowerClear, portStatusWrite, portPowerOn;
  logic [31:0] writeData, readData, statusWriteData, d, expQ[$];
  logic [31:0] hubStatusRead, port1StatusRead, port2StatusRead;
  integer      seed = 32'h5E50CC57, miscompares = 0, checks_done = 0, i;
  root_hub_descriptor_regs uut (.clock, .reset_n, .cmdCode, .cmdValid,
    .writeData, .readData, .readValid, .writeAccepted, .operationalState,
    .globalPowerSet, .globalPowerClear, .portPowerSet, .portPowerClear,
    .hubStatusWrite, .portStatusWrite, .statusWriteData, .hubStatusRead,
    .port1StatusRead, .port2StatusRead, .powerGoodDelay,
    .overcurrentEnabled, .overcurrentPerPort, .portPowerOn);
  initial
  begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task cmd(input [7:0] c, input [31:0] w, e, input rd, acc);
    @(posedge clock);
    #1 cmdValid = 1;
    cmdCode = c;
    writeData = w;
    if (rd)
      expQ.push_back(e);
    #1 check("writeAccepted", writeAccepted, acc);
    @(posedge clock);
    #1 cmdValid = 0;
  endtask
  task pwr(input [5:0] p, input [1:0] e);
    @(posedge clock);
    #1 {globalPowerSet, globalPowerClear, portPowerSet, portPowerClear} = p;
    @(posedge clock);
    #1 {globalPowerSet, globalPowerClear, portPowerSet, portPowerClear} = 0;
    repeat (2) @(posedge clock);
    #1 check("portPowerOn", portPowerOn, e);
  endtask
  always @(negedge clock)
    if (readValid === 1'b1)
      check("readData", readData, expQ.size() ? expQ.pop_front() : 'x);
  initial
  begin
    repeat (5000) @(posedge clock);
    miscompares++;
    report_and_stop;
  end
  initial
  begin
    {cmdValid, cmdCode, writeData, operationalState} = 0;
    {globalPowerSet, globalPowerClear, portPowerSet, portPowerClear} = 0;
    hubStatusRead = $random(seed);
    port1StatusRead = $random(seed);
    port2StatusRead = $random(seed);
    reset_n = 0;
    repeat (20) @(posedge clock);
    #1 reset_n = 1;
    cmd(8'h12, 0, 32'h19000902, 1, 0);
    cmd(8'h13, 0, 0, 1, 0);
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      d = i ? $random(seed) : 32'hFFFFFFFF;
      cmd(8'h92, d, 0, 0, 1);
      cmd(8'h12, 0, d & 32'hFF001B00 | 32'h2, 1, 0);
      check("ocEnabled", overcurrentEnabled, !d[12]);
      check("ocPerPort", overcurrentPerPort, !d[12] && d[11]);
      check("delay", powerGoodDelay, d[31:24]);
    end
    cmd(8'h93, 32'hFFFFFFFF, 0, 0, 1);
    cmd(8'h13, 0, 32'h00060006, 1, 0);
    $display("test descriptors done");
    for (i = 0; i < 6; i++)
    begin
      operationalState = i[0];
      d = $random(seed);
      cmd(8'h94 + i / 2, d, 0, 0, i[0]);
      check("hubWrite", hubStatusWrite, i == 1);
      check("portWrite", portStatusWrite, {i == 5, i == 3});
      if (i[0])
        check("statusData", statusWriteData, d);
    end
    cmd(8'h14, 0, hubStatusRead, 1, 0);
    cmd(8'h15, 0, port1StatusRead, 1, 0);
    cmd(8'h16, 0, port2StatusRead, 1, 0);
    $display("test status done");
    cmd(8'h92, 32'h200, 0, 0, 1);
    pwr(0, 2'h3);
    cmd(8'h92, 0, 0, 0, 1);
    pwr(6'h10, 0);
    pwr(6'h20, 2'h3);
    cmd(8'h93, 32'h00020000, 0, 0, 1);
    cmd(8'h92, 32'h900, 0, 0, 1);
    check("ocPerPort", overcurrentPerPort, 1'b1);
    pwr(6'h10, 2'h1);
    pwr(6'h01, 0);
    pwr(6'h04, 2'h1);
    cmd(8'h93, 32'h00060000, 0, 0, 1);
    pwr(6'h08, 2'h3);
    pwr(6'h10, 2'h3);
    pwr(6'h02, 2'h1);
    check("queueEmpty", expQ.size(), 0);
    $display("test power done");
    report_and_stop;
  end
endmodule // tb_top
bind root_hub_descriptor_regs root_hub_asserts chk (.clock, .reset_n,
  .cmdCode, .cmdValid, .writeData, .readData, .readValid, .writeAccepted,
  .operationalState, .hubStatusWrite, .portStatusWrite, .statusWriteData,
  .powerGoodDelay, .overcurrentEnabled, .overcurrentPerPort);
